// ### rtl/cascade_event_counter.sv
// Cascaded 24-bit external event counter with gate timer and AXI4-Lite registers
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps

module cascade_event_counter
    import evt24_pkg::*;
(
    input  wire logic              SYS_CLK,
    input  wire logic              RESET,
    input  wire logic              EVENT_INPUT_PIN,
    input  wire logic [ADDR_W-1:0] AWADDR,
    input  wire logic              AWVALID,
    output logic                   AWREADY,
    input  wire logic [DATA_W-1:0] WDATA,
    input  wire logic [3:0]        WSTRB,
    input  wire logic              WVALID,
    output logic                   WREADY,
    output logic [1:0]             BRESP,
    output logic                   BVALID,
    input  wire logic              BREADY,
    input  wire logic [ADDR_W-1:0] ARADDR,
    input  wire logic              ARVALID,
    output logic                   ARREADY,
    output logic [DATA_W-1:0]      RDATA,
    output logic [1:0]             RRESP,
    output logic                   RVALID,
    input  wire logic              RREADY,
    output logic                   UPPER_MATCH_IRQ,
    output logic                   COMPARE_B_IRQ,
    output logic                   LOWER_MATCH_IRQ,
    output logic                   GATE_TIMER_IRQ,
    output logic                   GATE_OUTPUT
);

    state_t           s_r;
    state_t           s_nxt;
    logic [PRE_W-1:0] pre_inc;
    logic             pin_rise;
    logic             pin_fall;
    logic             gate_level;
    logic             lower_tick;
    logic             upper_tick;
    logic             gate_tick;
    logic [32:0]      wr_look;
    logic [31:0]      wv;
    logic [32:0]      rd_look;

    // Prescaler tap tick: one pulse each time the chosen bit falls
    function automatic logic tap_tick(input logic [PRE_W-1:0] cur,
                                      input logic [PRE_W-1:0] inc,
                                      input logic [3:0]       idx);
        logic [3:0] i;
        i = (idx < 4'(PRE_W)) ? idx : 4'(PRE_W - 1);
        return cur[i] & ~inc[i];
    endfunction

    // Register read decode: bit 32 flags a mapped address
    function automatic logic [32:0] reg_word(input state_t st,
                                             input logic [ADDR_W-1:0] a);
        logic [32:0] r;
        r = 33'h0_0000_0000;
        case (a)
            OFS_UPPER_MODE:  r = {1'b1, 24'h00_0000, st.upper_mode};
            OFS_UPPER_PRESC: r = {1'b1, 24'h00_0000, st.upper_presc};
            OFS_CAP_CTRL:    r = {1'b1, 24'h00_0000, st.cap_ctrl};
            OFS_UPPER_OUT:   r = {1'b1, 24'h00_0000, st.upper_out};
            OFS_UPPER_CMP_A: r = {1'b1, 16'h0000, st.cmp_a};
            OFS_UPPER_CMP_B: r = {1'b1, 16'h0000, st.cmp_b};
            OFS_UPPER_CNT:   r = {1'b1, 16'h0000, st.upper_cnt};
            OFS_LOWER_CLK:   r = {1'b1, 24'h00_0000, st.lower_clk};
            OFS_LOWER_CMP:   r = {1'b1, 24'h00_0000, st.lower_cmp};
            OFS_LOWER_CTRL:  r = {1'b1, 24'h00_0000, st.lower_ctrl};
            OFS_LOWER_CNT:   r = {1'b1, 24'h00_0000, st.lower_cnt};
            OFS_GATE_MODE:   r = {1'b1, 24'h00_0000, st.gate_mode};
            OFS_GATE_PERIOD: r = {1'b1, 24'h00_0000, st.gate_period};
            OFS_GATE_DUTY:   r = {1'b1, 24'h00_0000, st.gate_duty};
            OFS_SWITCH:      r = {1'b1, 24'h00_0000, st.switch_reg};
            OFS_FLAGS:       r = {1'b1, 28'h000_0000, st.flags};
            default:         r = 33'h0_0000_0000;
        endcase
        return r;
    endfunction

    // Byte-lane merge of write data onto the current word
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] dat,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = dat[b*8 +: 8];
            end
        end
        return r;
    endfunction

    assign AWREADY         = ~s_r.aw_held & ~s_r.bvalid;
    assign WREADY          = ~s_r.w_held & ~s_r.bvalid;
    assign ARREADY         = ~s_r.rvalid;
    assign BVALID          = s_r.bvalid;
    assign BRESP           = s_r.bresp;
    assign RVALID          = s_r.rvalid;
    assign RDATA           = s_r.rdata;
    assign RRESP           = s_r.rresp;
    assign LOWER_MATCH_IRQ = s_r.irq[FLG_LOWER];
    assign UPPER_MATCH_IRQ = s_r.irq[FLG_UPPER];
    assign COMPARE_B_IRQ   = s_r.irq[FLG_CMPB];
    assign GATE_TIMER_IRQ  = s_r.irq[FLG_GATE];
    assign GATE_OUTPUT     = s_r.gate_out;

    always_comb begin
        s_nxt   = s_r;
        pre_inc = s_r.pre + 1'b1;
        s_nxt.pre = pre_inc;
        s_nxt.irq = 4'h0;
        s_nxt.cascade = 1'b0;

        // Pin synchroniser; a level counts once stages two and three agree
        s_nxt.pin_s = {s_r.pin_s[1:0], EVENT_INPUT_PIN};
        if (s_r.pin_s[1] == s_r.pin_s[2]) begin
            s_nxt.pin_lvl = s_r.pin_s[2];
        end
        pin_rise = s_nxt.pin_lvl & ~s_r.pin_lvl;
        pin_fall = ~s_nxt.pin_lvl & s_r.pin_lvl;

        // Gate level seen by the pin, resampled on every pin edge
        gate_level = s_r.gate_mode[GATE_OE_BIT] ? s_r.gate_out
                                                : s_r.gate_mode[GATE_IDLE_BIT];
        if (pin_rise | pin_fall) begin
            s_nxt.gate_seen = gate_level;
        end

        // Lower counter clock: pin edge or internal tap
        case (s_r.lower_clk)
            EDGE_FALL: lower_tick = pin_fall;
            EDGE_RISE: lower_tick = pin_rise;
            default:   lower_tick = tap_tick(s_r.pre, pre_inc, s_r.lower_clk[3:0]);
        endcase
        if (s_r.switch_reg[GATE_SW_BIT] && !s_r.gate_seen) begin
            lower_tick = 1'b0;
        end

        // Lower counter
        if (!s_r.lower_ctrl[LOWER_RUN_BIT]) begin
            s_nxt.lower_cnt = LOWER_CLEAR;
        end else if (lower_tick) begin
            if (s_r.lower_cnt == s_r.lower_cmp) begin
                s_nxt.lower_cnt = LOWER_CLEAR;
                s_nxt.cascade   = 1'b1;
                s_nxt.irq[FLG_LOWER] = 1'b1;
            end else begin
                s_nxt.lower_cnt = s_r.lower_cnt + 1'b1;
            end
        end

        // Upper counter clock select
        if (s_r.upper_presc[2:0] == PRESC_CASCADE) begin
            upper_tick = s_r.cascade;
        end else begin
            upper_tick = tap_tick(s_r.pre, pre_inc, {1'b0, s_r.upper_presc[2:0]});
        end

        // Upper counter
        if (s_r.upper_mode[UMODE_LSB +: 2] == UMODE_STOP) begin
            s_nxt.upper_cnt  = UPPER_CLEAR;
            s_nxt.first_skip = 1'b1;
        end else if (upper_tick) begin
            if (s_r.first_skip) begin
                s_nxt.first_skip = 1'b0;
            end else begin
                if (s_r.upper_mode[UMODE_LSB +: 2] == UMODE_CLR_A
                        && s_r.upper_cnt == s_r.cmp_a) begin
                    s_nxt.upper_cnt = UPPER_CLEAR;
                    s_nxt.irq[FLG_UPPER] = 1'b1;
                end else begin
                    s_nxt.upper_cnt = s_r.upper_cnt + 1'b1;
                end
                if (s_nxt.upper_cnt == s_r.cmp_b) begin
                    s_nxt.irq[FLG_CMPB] = 1'b1;
                end
            end
        end

        // Gate timer in PWM form
        gate_tick = tap_tick(s_r.pre, pre_inc,
                             {1'b0, s_r.gate_mode[GATE_CKS_LSB +: 3]});
        if (!s_r.gate_mode[GATE_RUN_BIT]) begin
            s_nxt.gate_cnt = RST_BYTE;
            s_nxt.gate_out = s_r.gate_mode[GATE_IDLE_BIT];
        end else if (gate_tick) begin
            if (s_r.gate_cnt == s_r.gate_period) begin
                s_nxt.gate_cnt = RST_BYTE;
                s_nxt.irq[FLG_GATE] = 1'b1;
                if (s_r.gate_mode[GATE_MD_LSB +: 2] == GATE_MD_PWM) begin
                    s_nxt.gate_out = ~s_r.gate_mode[GATE_IDLE_BIT];
                end
            end else begin
                s_nxt.gate_cnt = s_r.gate_cnt + 1'b1;
                if (s_r.gate_cnt == s_r.gate_duty) begin
                    s_nxt.gate_out = s_r.gate_mode[GATE_IDLE_BIT];
                end
            end
        end

        // AXI4-Lite write channels
        if (AWVALID && AWREADY) begin
            s_nxt.aw_held = 1'b1;
            s_nxt.awaddr  = AWADDR;
        end
        if (WVALID && WREADY) begin
            s_nxt.w_held = 1'b1;
            s_nxt.wdata  = WDATA;
            s_nxt.wstrb  = WSTRB;
        end
        if (s_r.bvalid && BREADY) begin
            s_nxt.bvalid = 1'b0;
        end
        wr_look = reg_word(s_r, s_r.awaddr);
        wv      = lane_merge(wr_look[31:0], s_r.wdata, s_r.wstrb);
        if (s_r.aw_held && s_r.w_held && !s_r.bvalid) begin
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held  = 1'b0;
            s_nxt.bvalid  = 1'b1;
            s_nxt.bresp   = wr_look[32] ? RESP_OKAY : RESP_SLVERR;
            case (s_r.awaddr)
                OFS_UPPER_MODE:  s_nxt.upper_mode  = wv[7:0];
                OFS_UPPER_PRESC: s_nxt.upper_presc = wv[7:0];
                OFS_CAP_CTRL:    s_nxt.cap_ctrl    = wv[7:0];
                OFS_UPPER_OUT:   s_nxt.upper_out   = wv[7:0];
                OFS_UPPER_CMP_A: s_nxt.cmp_a       = wv[15:0];
                OFS_UPPER_CMP_B: s_nxt.cmp_b       = wv[15:0];
                OFS_LOWER_CLK:   s_nxt.lower_clk   = wv[7:0];
                OFS_LOWER_CMP:   s_nxt.lower_cmp   = wv[7:0];
                OFS_LOWER_CTRL:  s_nxt.lower_ctrl  = wv[7:0];
                OFS_GATE_MODE:   s_nxt.gate_mode   = wv[7:0];
                OFS_GATE_PERIOD: s_nxt.gate_period = wv[7:0];
                OFS_GATE_DUTY:   s_nxt.gate_duty   = wv[7:0];
                OFS_SWITCH:      s_nxt.switch_reg  = wv[7:0];
                OFS_FLAGS:       s_nxt.flags = s_r.flags & ~(s_r.wdata[3:0]
                                               & {4{s_r.wstrb[0]}});
                default:         s_nxt.bresp = RESP_SLVERR;
            endcase
        end

        // Sticky flags; a new event wins over a clear in the same cycle
        s_nxt.flags = s_nxt.flags | s_nxt.irq;

        // AXI4-Lite read channels
        rd_look = reg_word(s_r, ARADDR);
        if (s_r.rvalid && RREADY) begin
            s_nxt.rvalid = 1'b0;
        end
        if (ARVALID && ARREADY) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata  = rd_look[31:0];
            s_nxt.rresp  = rd_look[32] ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule // cascade_event_counter

// ### shared/evt24_pkg.sv
// Package: register map, field positions and state record of the cascaded event counter
package evt24_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PRE_W  = 12;

    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_UPPER_MODE  = 8'h00;
    localparam logic [7:0] OFS_UPPER_PRESC = 8'h04;
    localparam logic [7:0] OFS_CAP_CTRL    = 8'h08;
    localparam logic [7:0] OFS_UPPER_OUT   = 8'h0C;
    localparam logic [7:0] OFS_UPPER_CMP_A = 8'h10;
    localparam logic [7:0] OFS_UPPER_CMP_B = 8'h14;
    localparam logic [7:0] OFS_UPPER_CNT   = 8'h18;
    localparam logic [7:0] OFS_LOWER_CLK   = 8'h1C;
    localparam logic [7:0] OFS_LOWER_CMP   = 8'h20;
    localparam logic [7:0] OFS_LOWER_CTRL  = 8'h24;
    localparam logic [7:0] OFS_LOWER_CNT   = 8'h28;
    localparam logic [7:0] OFS_GATE_MODE   = 8'h2C;
    localparam logic [7:0] OFS_GATE_PERIOD = 8'h30;
    localparam logic [7:0] OFS_GATE_DUTY   = 8'h34;
    localparam logic [7:0] OFS_SWITCH      = 8'h38;
    localparam logic [7:0] OFS_FLAGS       = 8'h3C;

    // Field positions and codes
    localparam int         UMODE_LSB      = 2;
    localparam logic [1:0] UMODE_STOP     = 2'b00;
    localparam logic [1:0] UMODE_CLR_A    = 2'b11;
    localparam logic [2:0] PRESC_CASCADE  = 3'b111;
    localparam logic [7:0] EDGE_FALL      = 8'h00;
    localparam logic [7:0] EDGE_RISE      = 8'h01;
    localparam int         LOWER_RUN_BIT  = 7;
    localparam int         GATE_RUN_BIT   = 7;
    localparam int         GATE_CKS_LSB   = 4;
    localparam int         GATE_MD_LSB    = 2;
    localparam logic [1:0] GATE_MD_PWM    = 2'b10;
    localparam int         GATE_IDLE_BIT  = 1;
    localparam int         GATE_OE_BIT    = 0;
    localparam int         GATE_SW_BIT    = 2;
    localparam int         FLG_LOWER      = 0;
    localparam int         FLG_UPPER      = 1;
    localparam int         FLG_CMPB       = 2;
    localparam int         FLG_GATE       = 3;

    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [15:0] RST_HALF    = 16'h0000;
    localparam logic [15:0] UPPER_CLEAR = 16'h0000;
    localparam logic [7:0]  LOWER_CLEAR = 8'h00;

    typedef struct packed {
        logic              aw_held;
        logic [ADDR_W-1:0] awaddr;
        logic              w_held;
        logic [DATA_W-1:0] wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
        logic [7:0]        upper_mode;
        logic [7:0]        upper_presc;
        logic [7:0]        cap_ctrl;
        logic [7:0]        upper_out;
        logic [15:0]       cmp_a;
        logic [15:0]       cmp_b;
        logic [15:0]       upper_cnt;
        logic              first_skip;
        logic [7:0]        lower_clk;
        logic [7:0]        lower_cmp;
        logic [7:0]        lower_ctrl;
        logic [7:0]        lower_cnt;
        logic [7:0]        gate_mode;
        logic [7:0]        gate_period;
        logic [7:0]        gate_duty;
        logic [7:0]        gate_cnt;
        logic              gate_out;
        logic [7:0]        switch_reg;
        logic [3:0]        flags;
        logic [PRE_W-1:0]  pre;
        logic [2:0]        pin_s;
        logic              pin_lvl;
        logic              gate_seen;
        logic              cascade;
        logic [3:0]        irq;
    } state_t;
endpackage

// ### verification/evt24_checker.sv
// Port checks for the cascaded event counter
`timescale 1ns/1ps
module evt24_checker
    import evt24_pkg::*;
(
    input wire logic       SYS_CLK,
    input wire logic       RESET,
    input wire logic       AWVALID,
    input wire logic       AWREADY,
    input wire logic       WVALID,
    input wire logic       WREADY,
    input wire logic       BVALID,
    input wire logic       BREADY,
    input wire logic       ARVALID,
    input wire logic       ARREADY,
    input wire logic       RVALID,
    input wire logic       RREADY,
    input wire logic       UPPER_MATCH_IRQ,
    input wire logic       COMPARE_B_IRQ,
    input wire logic       LOWER_MATCH_IRQ,
    input wire logic       GATE_TIMER_IRQ,
    input wire logic       GATE_OUTPUT
);
    default clocking dc @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    sequence lower_recent;
        $past(LOWER_MATCH_IRQ, 1) || $past(LOWER_MATCH_IRQ, 2) || $past(LOWER_MATCH_IRQ, 3)
            || $past(LOWER_MATCH_IRQ, 4);
    endsequence
    AST_LOWER_ONE_PULSE: assert property (LOWER_MATCH_IRQ |=> !LOWER_MATCH_IRQ)
        else $error("lower match pulse too long");
    AST_UPPER_FROM_LOWER: assert property (UPPER_MATCH_IRQ |-> lower_recent)
        else $error("upper match without lower match");
    AST_UPPER_ONE_PULSE: assert property (UPPER_MATCH_IRQ |=> !UPPER_MATCH_IRQ)
        else $error("upper match pulse too long");
    AST_CMPB_FROM_LOWER: assert property (COMPARE_B_IRQ |-> lower_recent)
        else $error("compare b pulse without lower match");
    AST_GATE_IRQ_LOW: assert property (GATE_TIMER_IRQ |-> !GATE_OUTPUT)
        else $error("gate pulse while gate output high");
    AST_GATE_FALL_AT_MATCH: assert property ($fell(GATE_OUTPUT) |-> GATE_TIMER_IRQ)
        else $error("gate output fell before period match");
    AST_READ_ANSWER: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read answer late");
    AST_WRITE_ANSWER: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
        else $error("write answer late");
    AST_B_BLOCK: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("write accepted while response pending");
    AST_R_CLEAR: assert property (RVALID && RREADY |=> !RVALID && ARREADY)
        else $error("read data not released");
    COV_UPPER: cover property (UPPER_MATCH_IRQ);
    COV_CMPB: cover property (COMPARE_B_IRQ);
    COV_GATE: cover property (GATE_TIMER_IRQ);
endmodule // evt24_checker

bind cascade_event_counter evt24_checker u_evt24_checker (.SYS_CLK(SYS_CLK), .RESET(RESET),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
    .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RVALID(RVALID), .RREADY(RREADY), .UPPER_MATCH_IRQ(UPPER_MATCH_IRQ),
    .COMPARE_B_IRQ(COMPARE_B_IRQ), .LOWER_MATCH_IRQ(LOWER_MATCH_IRQ),
    .GATE_TIMER_IRQ(GATE_TIMER_IRQ), .GATE_OUTPUT(GATE_OUTPUT));

// ### verification/event_source.sv
// Model of the external pulse source on the event pin
`timescale 1ns/1ps
module event_source (
    input  wire logic clk,
    output logic      event_pin
);
    localparam int HALF_W = 6;
    initial event_pin = 1'b0;
    // Set a level and hold it past the sync window
    task automatic level(input logic v);
        @(posedge clk);
        event_pin <= v;
        repeat (HALF_W) @(posedge clk);
    endtask
    // Whole pulses, high then low
    task automatic pulses(input int n);
        repeat (n) begin
            level(1'b1);
            level(1'b0);
        end
    endtask
endmodule // event_source

// ### verification/tb.sv
// Testbench for the cascaded event counter
`timescale 1ns/1ps
module tb;
    import evt24_pkg::*;
    logic              SYS_CLK = 1'b0;
    logic              RESET = 1'b1;
    logic              EVENT_INPUT_PIN;
    logic [ADDR_W-1:0] AWADDR;
    logic [ADDR_W-1:0] ARADDR;
    logic [DATA_W-1:0] WDATA;
    logic [DATA_W-1:0] RDATA;
    logic [3:0]        WSTRB;
    logic [1:0]        BRESP;
    logic [1:0]        RRESP;
    logic              AWVALID, WVALID, BREADY, ARVALID;
    logic              RREADY, AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic              UPPER_MATCH_IRQ, COMPARE_B_IRQ, LOWER_MATCH_IRQ, GATE_TIMER_IRQ;
    logic              GATE_OUTPUT;
    logic [31:0]       v0, v1, fl;
    int                checked = 0, bad_count = 0, up_irqs = 0, cb_irqs = 0, gt_irqs = 0;
    int                lo_irqs = 0;
    logic [7:0]        cfg_a [11] = '{OFS_UPPER_MODE, OFS_LOWER_CTRL, OFS_CAP_CTRL,
        OFS_UPPER_OUT, OFS_UPPER_PRESC, OFS_UPPER_CMP_A, OFS_UPPER_CMP_B, OFS_LOWER_CLK,
        OFS_LOWER_CMP, OFS_UPPER_MODE, OFS_LOWER_CTRL};
    logic [7:0]        cfg_d [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h02, 8'h01,
        8'h01, 8'hFF, 8'h0C, 8'h80};

    always #2.5 SYS_CLK = ~SYS_CLK;

    cascade_event_counter dut (.SYS_CLK(SYS_CLK), .RESET(RESET),
        .EVENT_INPUT_PIN(EVENT_INPUT_PIN), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
        .RVALID(RVALID), .RREADY(RREADY), .UPPER_MATCH_IRQ(UPPER_MATCH_IRQ),
        .COMPARE_B_IRQ(COMPARE_B_IRQ), .LOWER_MATCH_IRQ(LOWER_MATCH_IRQ),
        .GATE_TIMER_IRQ(GATE_TIMER_IRQ), .GATE_OUTPUT(GATE_OUTPUT));
    event_source src (.clk(SYS_CLK), .event_pin(EVENT_INPUT_PIN));

    // Pulse counters
    always @(negedge SYS_CLK) begin
        up_irqs += int'(UPPER_MATCH_IRQ === 1'b1);
        cb_irqs += int'(COMPARE_B_IRQ === 1'b1);
        gt_irqs += int'(GATE_TIMER_IRQ === 1'b1);
        lo_irqs += int'(LOWER_MATCH_IRQ === 1'b1); // Counted, checked at the end of the cascade test
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic       tk_aw, tk_w, done;
        logic [1:0] rsp;
        done = 1'b0;
        @(posedge SYS_CLK);
        AWADDR  <= a;
        WDATA   <= d;
        AWVALID <= 1'b1;
        WVALID  <= 1'b1;
        BREADY  <= 1'b1;
        while (!done) begin
            @(negedge SYS_CLK);
            tk_aw = AWVALID && AWREADY;
            tk_w  = WVALID && WREADY;
            done  = BVALID && BREADY;
            rsp   = BRESP;
            @(posedge SYS_CLK);
            if (tk_aw) AWVALID <= 1'b0;
            if (tk_w) WVALID <= 1'b0;
        end
        BREADY <= 1'b0;
        chk({30'h0, rsp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        logic       tk_ar, done;
        logic [1:0] rsp;
        done = 1'b0;
        @(posedge SYS_CLK);
        ARADDR  <= a;
        ARVALID <= 1'b1;
        RREADY  <= 1'b1;
        while (!done) begin
            @(negedge SYS_CLK);
            tk_ar = ARVALID && ARREADY;
            done  = RVALID && RREADY;
            d     = RDATA;
            rsp   = RRESP;
            @(posedge SYS_CLK);
            if (tk_ar) ARVALID <= 1'b0;
        end
        RREADY <= 1'b0;
        chk({30'h0, rsp}, {30'h0, er});
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        rd(a, d, er);
        chk(d, exp);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge SYS_CLK);
        bad_count++;
        end_sim();
    end

    initial begin
        AWADDR  <= '0;
        ARADDR  <= '0;
        WDATA   <= '0;
        WSTRB   <= 4'hF;
        AWVALID <= 1'b0;
        WVALID  <= 1'b0;
        BREADY  <= 1'b0;
        ARVALID <= 1'b0;
        RREADY  <= 1'b0;
        repeat (8) @(posedge SYS_CLK);
        RESET <= 1'b0;
        rdc(OFS_UPPER_CNT, 32'h0000_0000, RESP_OKAY);
        rdc(OFS_UPPER_CMP_A, 32'h0000_0000, RESP_OKAY);
        rdc(8'h40, 32'h0000_0000, RESP_SLVERR);
        rdc(8'h02, 32'h0000_0000, RESP_SLVERR);
        wr(8'h40, 32'h0000_0001, RESP_SLVERR);
        wr(OFS_LOWER_CNT, 32'h0000_0055, RESP_SLVERR);
        rdc(OFS_LOWER_CNT, 32'h0000_0000, RESP_OKAY);
        WSTRB <= 4'h2;
        wr(OFS_UPPER_CMP_B, 32'h0000_AB12, RESP_OKAY);
        WSTRB <= 4'hF;
        rdc(OFS_UPPER_CMP_B, 32'h0000_AB00, RESP_OKAY);
        $display("test registers done");
        for (int i = 0; i < 11; i++) wr(cfg_a[i], {24'h0, cfg_d[i]}, RESP_OKAY);
        rdc(OFS_UPPER_CMP_A, 32'h0000_0002, RESP_OKAY);
        src.pulses(10);
        rdc(OFS_LOWER_CNT, 32'h0000_000A, RESP_OKAY);
        src.pulses(246);
        rdc(OFS_LOWER_CNT, 32'h0000_0000, RESP_OKAY);
        rd(OFS_UPPER_CNT, v0, RESP_OKAY);
        chk(v0, 32'h0000_0000);
        rd(OFS_FLAGS, fl, RESP_OKAY);
        chk({8'h00, v0[15:0] + {15'h0, fl[FLG_LOWER]}, 8'h00}, 32'h0000_0100);
        wr(OFS_FLAGS, 32'h0000_000F, RESP_OKAY);
        rdc(OFS_FLAGS, 32'h0000_0000, RESP_OKAY);
        src.pulses(256);
        rdc(OFS_UPPER_CNT, 32'h0000_0001, RESP_OKAY);
        chk(32'(cb_irqs), 32'h0000_0001);
        src.pulses(512);
        rd(OFS_UPPER_CNT, v0, RESP_OKAY);
        chk(v0, 32'h0000_0000);
        chk(32'(up_irqs), 32'h0000_0001);
        chk(32'(lo_irqs), 32'h0000_0004);
        $display("test cascade done");
        wr(OFS_LOWER_CTRL, 32'h0000_0000, RESP_OKAY);
        rdc(OFS_LOWER_CNT, 32'h0000_0000, RESP_OKAY);
        wr(OFS_LOWER_CLK, 32'h0000_0000, RESP_OKAY);
        wr(OFS_LOWER_CTRL, 32'h0000_0080, RESP_OKAY);
        src.level(1'b1);
        rdc(OFS_LOWER_CNT, 32'h0000_0000, RESP_OKAY);
        src.level(1'b0);
        rdc(OFS_LOWER_CNT, 32'h0000_0001, RESP_OKAY);
        $display("test edge done");
        wr(OFS_SWITCH, 32'h0000_0004, RESP_OKAY);
        src.pulses(6);
        rd(OFS_LOWER_CNT, v0, RESP_OKAY);
        chk(v0, 32'h0000_0001);
        wr(OFS_GATE_MODE, 32'h0000_000B, RESP_OKAY);
        src.pulses(4);
        rd(OFS_LOWER_CNT, v1, RESP_OKAY);
        chk({31'h0, v1 - v0 >= 32'h3 && v1 - v0 <= 32'h4}, 32'h0000_0001);
        wr(OFS_GATE_PERIOD, 32'h0000_0010, RESP_OKAY);
        wr(OFS_GATE_DUTY, 32'h0000_0004, RESP_OKAY);
        wr(OFS_GATE_MODE, 32'h0000_008B, RESP_OKAY);
        @(negedge SYS_CLK);
        chk({31'h0, GATE_OUTPUT}, 32'h0000_0001);
        repeat (300) @(posedge SYS_CLK);
        chk({31'h0, gt_irqs > 0}, 32'h0000_0001);
        $display("test gate done");
        end_sim();
    end
endmodule // tb
